// ### design/sct_pkg.sv
// package: register map, field layout and constants of the capture timer
package sct_pkg;
    // ==========================================================
    // register byte offsets (apb, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CNT_LO = 8'h04;
    localparam logic [7:0] ADDR_CNT_HI = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_CH_CTRL0 = 8'h14;
    localparam logic [7:0] ADDR_CH_CAP0 = 8'h20;
    localparam logic [7:0] ADDR_RADIO_MASK = 8'h2c;
    localparam int NUM_CH = 3;
    // ==========================================================
    // ctrl fields: [1:0] mode, [3:2] prescale, [6:4] tick speed, [7] irq enable
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIV_LSB = 2;
    localparam int CTRL_TICK_LSB = 4;
    localparam int CTRL_IRQ_EN_BIT = 7;
    // status/mask: [2:0] channel flags, [3] terminal count
    localparam int STAT_TC_BIT = 3;
    // channel ctrl: [1:0] edge select, [2] capture enable, [3] radio select
    localparam int CHC_CAP_BIT = 2;
    localparam int CHC_RADIO_BIT = 3;
    // ==========================================================
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] PRE_8 = 7'h07;
    localparam logic [6:0] PRE_32 = 7'h1f;
    localparam logic [6:0] PRE_128 = 7'h7f;
    typedef enum logic [1:0] {
        MODE_STOP = 2'h0, MODE_FREE = 2'h1, MODE_MOD = 2'h2, MODE_UPDN = 2'h3
    } sct_mode_type;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2, EDGE_ANY = 2'h3
    } sct_edge_type;
    typedef enum logic [1:0] {
        DIR_UP = 2'h1, DIR_DOWN = 2'h2
    } sct_dir_type;
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } sct_apb_req_type;
endpackage

// ### design/sct_timer.sv
// capture timer: 16-bit counter, prescaler, three capture channels, apb regs
`timescale 1ns/100ps
module sct_timer
    import sct_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire sct_apb_req_type apb_in,
    input wire logic [2:0] cap_pin_in,
    input wire logic [7:0] radio_event_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic cpu_timer_flag_out,
    output logic irq_out
);
    // ==========================================================
    // bus decode
    logic acc;
    logic wr;
    logic rd_setup;
    assign acc = apb_in.psel && apb_in.penable && pready_out;
    assign wr = acc && apb_in.pwrite;
    // read data and the high byte snapshot are taken at the same edge
    assign rd_setup = apb_in.psel && !apb_in.penable && !apb_in.pwrite;

    logic [7:0] ctrl_q;
    logic [3:0] mask_q;
    logic [3:0] stat_q;
    logic [3:0] chc_q [NUM_CH];
    logic [15:0] cap_q [NUM_CH];
    logic [7:0] radio_mask_q;
    logic [15:0] cnt_q;
    logic [7:0] cnt_hi_q;
    logic [6:0] pre_q;
    logic [6:0] tick_q;
    sct_dir_type dir_q;
    sct_mode_type mode;
    assign mode = sct_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);

    // ==========================================================
    // tick generation
    logic [6:0] tick_lim;
    logic [6:0] pre_lim;
    logic tick_en;
    logic cnt_step;
    // tick speed divides only the timer tick, system clock untouched
    assign tick_lim = 7'((7'h01 << ctrl_q[CTRL_TICK_LSB +: 3]) - 7'h01);
    always_comb begin
        case (ctrl_q[CTRL_DIV_LSB +: 2])
            2'h1: pre_lim = PRE_8;
            2'h2: pre_lim = PRE_32;
            2'h3: pre_lim = PRE_128;
            default: pre_lim = 7'h00;
        endcase
    end
    assign tick_en = (tick_q >= tick_lim);
    assign cnt_step = tick_en && (pre_q == pre_lim) && (mode != MODE_STOP);

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_q <= 7'h00;
        end else if (tick_en) begin
            tick_q <= 7'h00;
        end else begin
            tick_q <= 7'(tick_q + 7'h01);
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_q <= 7'h00;
        end else if (tick_en) begin
            pre_q <= (pre_q >= pre_lim) ? 7'h00 : 7'(pre_q + 7'h01);
        end
    end

    // ==========================================================
    // counter
    logic [15:0] period;
    logic [15:0] cnt_d;
    sct_dir_type dir_d;
    logic tc_evt;
    assign period = cap_q[0];
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        tc_evt = 1'b0;
        case (mode)
            MODE_FREE: begin
                cnt_d = (cnt_q == CNT_MAX) ? CNT_RESET : 16'(cnt_q + 16'h0001);
                tc_evt = (cnt_q == CNT_MAX);
                dir_d = DIR_UP;
            end
            MODE_MOD: begin
                cnt_d = (cnt_q >= period) ? CNT_RESET : 16'(cnt_q + 16'h0001);
                tc_evt = (cnt_q == period);
                dir_d = DIR_UP;
            end
            MODE_UPDN: begin
                if (dir_q == DIR_UP) begin
                    if (cnt_q >= period) begin
                        dir_d = DIR_DOWN;
                        cnt_d = (cnt_q == CNT_RESET) ? CNT_RESET : 16'(cnt_q - 16'h0001);
                    end else begin
                        cnt_d = 16'(cnt_q + 16'h0001);
                    end
                end else begin
                    if (cnt_q == CNT_RESET) begin
                        dir_d = DIR_UP;
                        cnt_d = 16'h0001;
                    end else begin
                        cnt_d = 16'(cnt_q - 16'h0001);
                    end
                end
                tc_evt = (cnt_d == CNT_RESET) && (cnt_q != CNT_RESET);
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    logic cnt_lo_wr;
    assign cnt_lo_wr = wr && (apb_in.paddr == ADDR_CNT_LO);
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= CNT_RESET;
            dir_q <= DIR_UP;
        end else if (cnt_lo_wr) begin
            cnt_q <= CNT_RESET;
            dir_q <= DIR_UP;
        end else if (cnt_step) begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // high byte snapshot on low byte read
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_hi_q <= REG_RESET;
        end else if (rd_setup && apb_in.paddr == ADDR_CNT_LO) begin
            cnt_hi_q <= cnt_q[15:8];
        end
    end

    // ==========================================================
    // capture channels
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [7:0] rad_s1_q;
    logic [7:0] rad_s2_q;
    logic [7:0] rad_s3_q;
    logic [2:0] cap_evt;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
            rad_s1_q <= 8'h00;
            rad_s2_q <= 8'h00;
            rad_s3_q <= 8'h00;
        end else begin
            pin_s1_q <= cap_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            rad_s1_q <= radio_event_in;
            rad_s2_q <= rad_s1_q;
            rad_s3_q <= rad_s2_q;
        end
    end

    logic radio_hit;
    assign radio_hit = |(rad_s2_q & ~rad_s3_q & radio_mask_q);
    // each channel decodes its own pin edge; radio_hit is one decode shared by all channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic rise;
        logic fall;
        logic pin_hit;
        assign rise = pin_s2_q[i] && !pin_s3_q[i];
        assign fall = !pin_s2_q[i] && pin_s3_q[i];
        always_comb begin
            case (sct_edge_type'(chc_q[i][1:0]))
                EDGE_RISE: pin_hit = rise;
                EDGE_FALL: pin_hit = fall;
                EDGE_ANY: pin_hit = rise || fall;
                default: pin_hit = 1'b0;
            endcase
        end
        assign cap_evt[i] = chc_q[i][CHC_CAP_BIT] && (mode != MODE_STOP) &&
            (chc_q[i][CHC_RADIO_BIT] ? radio_hit : pin_hit);
        always_ff @(posedge core_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                cap_q[i] <= CNT_RESET;
            end else if (cap_evt[i]) begin
                cap_q[i] <= cnt_q;
            end else if (wr && apb_in.paddr == 8'(ADDR_CH_CAP0 + 8'(4 * i))) begin
                cap_q[i] <= apb_in.pwdata[15:0];
            end
        end
        always_ff @(posedge core_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                chc_q[i] <= 4'h0;
            end else if (wr && apb_in.paddr == 8'(ADDR_CH_CTRL0 + 8'(4 * i))) begin
                chc_q[i] <= apb_in.pwdata[3:0];
            end
        end
        AST_CAP_CH: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
            cap_evt[i] |=> cap_q[i] == $past(cnt_q) && stat_q[i])
            else $error("channel capture lost");
        AST_STOP_NO_CAP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
            (mode == MODE_STOP) |-> !cap_evt[i]) else $error("capture while halted");
        AST_RADIO_SEL: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
            (chc_q[i][CHC_CAP_BIT] && chc_q[i][CHC_RADIO_BIT] && mode != MODE_STOP && radio_hit)
            |-> cap_evt[i]) else $error("radio event missed");
    end

    // ==========================================================
    // control, mask and flags
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= REG_RESET;
            mask_q <= 4'h0;
            radio_mask_q <= REG_RESET;
        end else if (wr) begin
            if (apb_in.paddr == ADDR_CTRL) begin
                ctrl_q <= apb_in.pwdata[7:0];
            end
            if (apb_in.paddr == ADDR_MASK) begin
                mask_q <= apb_in.pwdata[3:0];
            end
            if (apb_in.paddr == ADDR_RADIO_MASK) begin
                radio_mask_q <= apb_in.pwdata[7:0];
            end
        end
    end

    // flags set regardless of mask; set wins over write-one clear
    logic [3:0] stat_clr;
    logic [3:0] stat_set;
    assign stat_clr = (wr && apb_in.paddr == ADDR_STATUS) ? apb_in.pwdata[3:0] : 4'h0;
    assign stat_set = {cnt_step && tc_evt, cap_evt};
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stat_q <= 4'h0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpu_timer_flag_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            cpu_timer_flag_out <= |(stat_q & mask_q);
            irq_out <= |(stat_q & mask_q) && ctrl_q[CTRL_IRQ_EN_BIT];
        end
    end

    // ==========================================================
    // read path, no wait state
    logic [31:0] rdata;
    logic hit;
    always_comb begin
        rdata = 32'h0;
        hit = 1'b1;
        case (apb_in.paddr)
            ADDR_CTRL: rdata = {24'h0, ctrl_q};
            ADDR_CNT_LO: rdata = {24'h0, cnt_q[7:0]};
            ADDR_CNT_HI: rdata = {24'h0, cnt_hi_q};
            ADDR_STATUS: rdata = {28'h0, stat_q};
            ADDR_MASK: rdata = {28'h0, mask_q};
            8'h14: rdata = {28'h0, chc_q[0]};
            8'h18: rdata = {28'h0, chc_q[1]};
            8'h1c: rdata = {28'h0, chc_q[2]};
            8'h20: rdata = {16'h0, cap_q[0]};
            8'h24: rdata = {16'h0, cap_q[1]};
            8'h28: rdata = {16'h0, cap_q[2]};
            ADDR_RADIO_MASK: rdata = {24'h0, radio_mask_q};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= apb_in.psel && !apb_in.penable;
            prdata_out <= rd_setup ? rdata : 32'h0;
            pslverr_out <= apb_in.psel && !apb_in.penable && !hit;
        end
    end

    // ==========================================================
    // checks
    AST_CNT_CLR: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        cnt_lo_wr |=> cnt_q == CNT_RESET) else $error("count not cleared by low write");
    AST_HALT: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (mode == MODE_STOP && !cnt_lo_wr) |=> $stable(cnt_q)) else $error("halted counter moved");
    AST_FREE_WRAP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_FREE && cnt_q == CNT_MAX && !cnt_lo_wr)
        |=> cnt_q == CNT_RESET && stat_q[STAT_TC_BIT]) else $error("free wrap wrong");
    AST_MOD_WRAP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_MOD && cnt_q == period && !cnt_lo_wr)
        |=> cnt_q == CNT_RESET && stat_q[STAT_TC_BIT]) else $error("modulo wrap wrong");
    AST_HI_LATCH: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (rd_setup && apb_in.paddr == ADDR_CNT_LO) |=> cnt_hi_q == $past(cnt_q[15:8]))
        else $error("high byte not latched");
    AST_CAP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        cap_evt[1] |=> cap_q[1] == $past(cnt_q) && stat_q[1]) else $error("capture lost");
    AST_IRQ: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (stat_q[STAT_TC_BIT] && mask_q[STAT_TC_BIT] && ctrl_q[CTRL_IRQ_EN_BIT])
        |=> cpu_timer_flag_out && irq_out) else $error("irq not raised");
    AST_NO_IRQ: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (!ctrl_q[CTRL_IRQ_EN_BIT]) |=> !irq_out) else $error("irq without enable");
    AST_PRE: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        cnt_step |-> pre_q == pre_lim) else $error("prescale bypassed");

    // ==========================================================
    // counting, flag and bus checks
    AST_NO_STEP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (!cnt_step && !cnt_lo_wr) |=> $stable(cnt_q)) else $error("count moved between ticks");
    AST_FREE_STEP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_FREE && cnt_q != CNT_MAX && !cnt_lo_wr)
        |=> cnt_q == 16'($past(cnt_q) + 16'h0001)) else $error("free count did not step");
    AST_MOD_STEP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_MOD && cnt_q < period && !cnt_lo_wr)
        |=> cnt_q == 16'($past(cnt_q) + 16'h0001)) else $error("modulo count did not step");
    AST_UPDN_TOP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_UPDN && dir_q == DIR_UP && cnt_q == period &&
        period != CNT_RESET && !cnt_lo_wr)
        |=> dir_q == DIR_DOWN && cnt_q == 16'($past(cnt_q) - 16'h0001))
        else $error("no turn at period");
    AST_UPDN_ZERO: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && mode == MODE_UPDN && dir_q == DIR_DOWN && cnt_q == 16'h0001 && !cnt_lo_wr)
        |=> cnt_q == CNT_RESET && stat_q[STAT_TC_BIT]) else $error("no flag at zero");
    AST_TC_UNMASKED: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (cnt_step && tc_evt && !mask_q[STAT_TC_BIT]) |=> stat_q[STAT_TC_BIT])
        else $error("terminal flag held back by mask");
    AST_TC_CLR: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (wr && apb_in.paddr == ADDR_STATUS && apb_in.pwdata[STAT_TC_BIT] &&
        !(cnt_step && tc_evt))
        |=> !stat_q[STAT_TC_BIT]) else $error("terminal flag not cleared");
    AST_CPU_MASK: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        ((stat_q & mask_q) == 4'h0) |=> !cpu_timer_flag_out && !irq_out)
        else $error("flag raised without mask");
    AST_HI_HOLD: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !(rd_setup && apb_in.paddr == ADDR_CNT_LO) |=> $stable(cnt_hi_q))
        else $error("high byte changed without low read");
    AST_ERR_PAIR: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        pslverr_out |-> pready_out) else $error("error without ready");
endmodule

// ### dv/sct_pin_model.sv
// capture pin and radio event source on the far side of the timer
`timescale 1ns/100ps
module sct_pin_model (
    input wire logic clk_in,
    output logic [2:0] cap_pin_out,
    output logic [7:0] radio_event_out
);
    initial begin
        cap_pin_out = 3'h0;
        radio_event_out = 8'h00;
    end
    // a new pin level is held four clocks, well over one clock period
    task automatic pin_set(input int ch, input logic val);
        @(posedge clk_in);
        cap_pin_out[ch] <= val;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic radio_pulse(input int b);
        @(posedge clk_in);
        radio_event_out[b] <= 1'b1;
        repeat (4) @(posedge clk_in);
        radio_event_out[b] <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ### dv/tb_sixteen_bit_capture_timer.sv
// self-checking bench for the capture timer
`timescale 1ns/100ps
module tb_sixteen_bit_capture_timer;
    import sct_pkg::*;
    logic clk;
    logic nrst;
    sct_apb_req_type apb;
    logic [2:0] pins;
    logic [7:0] radio;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_flag;
    logic irq;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int total_checks = 0;

    sct_timer DUT (.core_clk_in(clk), .nrst_in(nrst), .apb_in(apb), .cap_pin_in(pins),
        .radio_event_in(radio), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cpu_timer_flag_out(cpu_flag), .irq_out(irq));
    sct_pin_model PIN (.clk_in(clk), .cap_pin_out(pins), .radio_event_out(radio));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // apb master and compare tasks
    task automatic fail(input string m, input logic [31:0] g);
        miscompares++;
        $display("[FAIL] %0t %s got %h", $time, m, g);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail($sformatf("expected %h", e), g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail("no pready", 32'h0);
        end
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic rrange(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        xfer(1'b0, a, 32'h0);
        total_checks++;
        if ((rd >= lo && rd <= hi) !== 1'b1) begin
            fail("value out of range", rd);
        end
    endtask
    task automatic flags(input logic [31:0] e);
        repeat (3) @(negedge clk);
        chk({30'h0, cpu_flag, irq}, e);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_STATUS, 32'h0);
        rchk(ADDR_CNT_LO, 32'h0);
        xfer(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_prescale();
        int f[4] = '{1, 8, 32, 128};
        for (int d = 0; d < 4; d++) begin
            wreg(ADDR_CNT_LO, 32'h5a);
            wreg(ADDR_CTRL, 32'(d * 4 + 1));
            repeat (f[d] * 8) @(posedge clk);
            wreg(ADDR_CTRL, 32'(d * 4));
            rrange(ADDR_CNT_LO, 32'd7, 32'd12);
            repeat (20) @(posedge clk);
            rchk(ADDR_CNT_LO, rd);
        end
        wreg(ADDR_CNT_LO, 32'h0);
        wreg(ADDR_CTRL, 32'h31);
        repeat (64) @(posedge clk);
        wreg(ADDR_CTRL, 32'h30);
        rrange(ADDR_CNT_LO, 32'd7, 32'd12);
        $display("test prescale done");
    endtask
    task automatic t_latch();
        wreg(ADDR_CNT_LO, 32'h0);
        wreg(ADDR_CTRL, 32'h1);
        repeat (336) @(posedge clk);
        xfer(1'b0, ADDR_CNT_LO, 32'h0);
        repeat (256) @(posedge clk);
        rchk(ADDR_CNT_HI, 32'h01);
        $display("test latch done");
    endtask
    task automatic t_period(input logic [31:0] mode, input logic [31:0] per);
        wreg(ADDR_CTRL, 32'h0);
        wreg(ADDR_CH_CAP0, per);
        wreg(ADDR_CNT_LO, 32'h0);
        wreg(ADDR_STATUS, 32'hf);
        wreg(ADDR_CTRL, mode);
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS, (mode == 32'h3) ? 32'h0 : 32'h8);
        repeat (12) rrange(ADDR_CNT_LO, 32'h0, per);
        rchk(ADDR_STATUS, 32'h8);
        $display("test period done");
    endtask
    task automatic t_overflow();
        int n = 0;
        wreg(ADDR_CTRL, 32'h0);
        wreg(ADDR_CNT_LO, 32'h0);
        wreg(ADDR_STATUS, 32'hf);
        wreg(ADDR_CTRL, 32'h1);
        rchk(ADDR_STATUS, 32'h0);
        do begin
            xfer(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (rd === 32'h0 && n < 25000);
        chk(rd, 32'h8);
        rrange(ADDR_CNT_LO, 32'h0, 32'h10);
        wreg(ADDR_CTRL, 32'h0);
        flags(32'h0);
        wreg(ADDR_MASK, 32'h8);
        flags(32'h2);
        wreg(ADDR_CTRL, 32'h80);
        flags(32'h3);
        wreg(ADDR_STATUS, 32'h8);
        flags(32'h0);
        $display("test overflow done");
    endtask
    task automatic t_capture();
        wreg(ADDR_MASK, 32'h0);
        wreg(ADDR_CNT_LO, 32'h0);
        wreg(ADDR_CTRL, 32'h85);
        repeat (40) @(posedge clk);
        for (int c = 0; c < 3; c++) begin
            wreg(ADDR_CH_CTRL0 + 8'(4 * c), 32'(5 + c));
            rchk(ADDR_CH_CTRL0 + 8'(4 * c), 32'(5 + c));
            wreg(ADDR_STATUS, 32'hf);
            PIN.pin_set(c, 1'b1);
            rchk(ADDR_STATUS, (c == 1) ? 32'h0 : 32'(1 << c));
            PIN.pin_set(c, 1'b0);
            rchk(ADDR_STATUS, 32'(1 << c));
            rrange(ADDR_CH_CAP0 + 8'(4 * c), 32'h1, 32'h100);
        end
        flags(32'h0);
        wreg(ADDR_MASK, 32'h4);
        flags(32'h3);
        $display("test capture done");
    endtask
    task automatic t_radio();
        wreg(ADDR_CTRL, 32'h81);
        wreg(ADDR_RADIO_MASK, 32'h4);
        wreg(ADDR_CH_CTRL0 + 8'h8, 32'hd);
        wreg(ADDR_STATUS, 32'hf);
        PIN.radio_pulse(1);
        PIN.pin_set(2, 1'b1);
        PIN.pin_set(2, 1'b0);
        rchk(ADDR_STATUS, 32'h0);
        PIN.radio_pulse(2);
        rchk(ADDR_STATUS, 32'h4);
        rrange(ADDR_CH_CAP0 + 8'h8, 32'h1, 32'hffff);
        flags(32'h3);
        $display("test radio done");
    endtask
    task automatic t_midreset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        flags(32'h0);
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_STATUS, 32'h0);
        repeat (20) @(posedge clk);
        rchk(ADDR_CNT_LO, 32'h0);
        $display("test midreset done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        nrst = 1'b0;
        apb = '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_prescale();
        t_latch();
        t_period(32'h2, 32'h4);
        t_period(32'h3, 32'h6);
        t_overflow();
        t_capture();
        t_radio();
        t_midreset();
        complete_run();
    end
    initial begin
        #500000;
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
